// [rtl/phy_status_pkg.sv]
package phy_status_pkg;
   localparam logic [4:0] STATUS_ADDR = 5'h01;
   localparam logic [15:0] STATUS_RESET = 16'h7809;
   localparam int BIT_T4 = 15;
   localparam int BIT_TX_FD = 14;
   localparam int BIT_TX_HD = 13;
   localparam int BIT_10_FD = 12;
   localparam int BIT_10_HD = 11;
   localparam int BIT_RSVD_HI = 10;
   localparam int BIT_RSVD_LO = 7;
   localparam int BIT_PREAMBLE = 6;
   localparam int BIT_AN_DONE = 5;
   localparam int BIT_RFAULT = 4;
   localparam int BIT_AN_ABLE = 3;
   localparam int BIT_LINK = 2;
   localparam int BIT_JABBER = 1;
   localparam int BIT_EXT_CAP = 0;
   localparam logic [15:0] OVR_MASK = 16'h7FC0;
   localparam logic [15:0] RSVD_MASK = 16'h0780;
endpackage

// [rtl/phy_status_register.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Any reset loads every status bit with its default value.
// - Station manager reads this register only at management address one.
// - Bit 15 always reads zero and ignores writes.
// - Bit 14 defaults one, writable only with override write enable.
// - Bit 13 defaults one, writable only with override write enable.
// - Bit 12 defaults one, writable only with override write enable.
// - Bit 11 defaults one, writable only with override write enable.
// - Bit 6 reports preamble suppression ability, defaulting to zero.
// - Bit 5 latches high on negotiation completion while negotiation is enabled, until read.
// - Bit 4 latches high on remote fault; read here or mirror clears it.
// - Bit 2 latches low on link loss until read.
// - Bit 1 latches high on jabber; read here or mirror clears it.
module phy_status_register
   import phy_status_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [4:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic override_writable,
   input wire logic mirror_rd,
   input wire logic an_enabled,
   input wire logic an_complete,
   input wire logic remote_fault,
   input wire logic link_ok,
   input wire logic jabber,
   output logic [15:0] reg_rdata
);
   // Override-writable capability bits, kept as a full word so field positions stay readable.
   logic [15:0] ovr_bits;
   logic [15:0] next_ovr_bits;
   // Latched status bits and their next values.
   logic an_done;
   logic next_an_done;
   logic rfault;
   logic next_rfault;
   logic link;
   logic next_link;
   logic jab;
   logic next_jab;
   logic [15:0] next_rdata;

   // Set wins over clear, so an event that lands in the read cycle is still seen by the next read.
   function automatic logic latch_high_next(
      input logic held,
      input logic ev_now,
      input logic clear
   );
      latch_high_next = ev_now || (held && !clear);
   endfunction

   // A latch-low bit recovers only on a read, and only if the live condition is good at that edge.
   function automatic logic latch_low_next(
      input logic held,
      input logic live_now,
      input logic clear
   );
      latch_low_next = live_now && (held || clear);
   endfunction

   // The decode and its checks compare against the one management address.
   function automatic logic addr_match(
      input logic [4:0] addr
   );
      addr_match = (addr == STATUS_ADDR);
   endfunction

   // Reserved bits are dropped on a store; the station is expected to send zeros there.
   function automatic logic [15:0] store_filter(
      input logic [15:0] word
   );
      store_filter = word & OVR_MASK & ~RSVD_MASK;
   endfunction

   wire sel = addr_match(reg_addr);
   wire rd_hit = reg_rd && sel;
   wire wr_hit = reg_wr && sel;
   wire wr_ovr = wr_hit && override_writable;
   // Remote fault and jabber are shared with the quick-poll mirror, so either read releases them.
   wire shared_rd = rd_hit || mirror_rd;
   // Completion only counts while negotiation is enabled.
   wire an_live = an_enabled && an_complete;

   wire [15:0] live_word = {1'b0, ovr_bits[14:11], 4'h0, ovr_bits[BIT_PREAMBLE],
                            an_done, rfault, 1'b1, link, jab, 1'b1};

   assign next_ovr_bits = wr_ovr ? store_filter(reg_wdata) : ovr_bits;
   assign next_an_done = latch_high_next(an_done, an_live, rd_hit);
   assign next_rfault = latch_high_next(rfault, remote_fault, shared_rd);
   assign next_link = latch_low_next(link, link_ok, rd_hit);
   assign next_jab = latch_high_next(jab, jabber, shared_rd);
   // The read data holds between reads, so the station may sample it at any later time.
   assign next_rdata = rd_hit ? live_word : reg_rdata;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ovr_bits <= STATUS_RESET & OVR_MASK;
      end else begin
         ovr_bits <= next_ovr_bits;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         an_done <= STATUS_RESET[BIT_AN_DONE];
      end else begin
         an_done <= next_an_done;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rfault <= STATUS_RESET[BIT_RFAULT];
      end else begin
         rfault <= next_rfault;
      end
   end

   // Link starts low after reset, so the first read reports the link as down.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         link <= STATUS_RESET[BIT_LINK];
      end else begin
         link <= next_link;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         jab <= STATUS_RESET[BIT_JABBER];
      end else begin
         jab <= next_jab;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Fixed fields of the read word.
   t4_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_T4] == 1'b0) else $error("t4 bit read nonzero");
   fixed_ones_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_AN_ABLE] && reg_rdata[BIT_EXT_CAP]) else $error("fixed ones lost");
   rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> (reg_rdata & RSVD_MASK) == 16'h0000) else $error("reserved bits nonzero");
   ovr_clean_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ovr_bits & ~(OVR_MASK & ~RSVD_MASK)) == 16'h0000) else $error("fixed bit stored");

   // Override-writable capability bits and read data hold.
   ovr_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(reg_wr && override_writable) |=> $stable(ovr_bits)) else $error("capability bits moved");
   ovr_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_ovr |=> ovr_bits[14:11] == $past(reg_wdata[14:11])) else $error("capability write lost");
   ovr_bit12_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_ovr |=> ovr_bits[BIT_10_FD] == $past(reg_wdata[BIT_10_FD])) else $error("bit 12 write lost");
   pre_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_ovr |=> ovr_bits[BIT_PREAMBLE] == $past(reg_wdata[BIT_PREAMBLE])) else $error("bit 6 write lost");
   addr_miss_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_wr && !addr_match(reg_addr) |=> $stable(ovr_bits)) else $error("foreign write landed");
   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !rd_hit |=> $stable(reg_rdata)) else $error("read data moved");

   // Latched status bits and the bit 6 read.
   an_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      an_live ##1 !rd_hit |=> an_done) else $error("an done not held");
   an_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !an_enabled && !an_done |=> !an_done) else $error("an done set while disabled");
   an_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit && !an_live |=> !an_done) else $error("an done not released");
   read_an_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_AN_DONE] == $past(an_done)) else $error("an done read wrong");
   rf_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      remote_fault |=> rfault) else $error("remote fault not latched");
   rf_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rfault && !shared_rd |=> rfault) else $error("remote fault dropped");
   rf_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      shared_rd && !remote_fault |=> !rfault) else $error("remote fault not cleared");
   link_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !link_ok ##1 !rd_hit |=> !link) else $error("link loss not held");
   link_up_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit && link_ok |=> link) else $error("link not restored");
   read_link_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_LINK] == $past(link)) else $error("link read wrong");
   jab_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      jabber |=> jab) else $error("jabber not latched");
   jab_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      jab && !shared_rd |=> jab) else $error("jabber dropped");
   jab_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      mirror_rd && !jabber |=> !jab) else $error("jabber not cleared");
   read_pre_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_PREAMBLE] == $past(ovr_bits[BIT_PREAMBLE])) else $error("bit 6 read wrong");

   // Reset values.
   reset_val_a: assert property (@(posedge sys_clk)
      !nrst |=> ovr_bits == (STATUS_RESET & OVR_MASK) && !an_done && !link) else $error("bad reset value");
   rdata_zero_a: assert property (@(posedge sys_clk)
      !nrst |=> reg_rdata == 16'h0000) else $error("read data not cleared");

   read_c: cover property (@(posedge sys_clk) disable iff (!nrst) rd_hit && an_done);
   ovr_c: cover property (@(posedge sys_clk) disable iff (!nrst) wr_ovr);
   link_c: cover property (@(posedge sys_clk) disable iff (!nrst) !link ##1 rd_hit ##1 link);
   rf_mirror_c: cover property (@(posedge sys_clk) disable iff (!nrst) rfault ##1 mirror_rd);
   jab_c: cover property (@(posedge sys_clk) disable iff (!nrst) jabber ##1 !jabber ##1 mirror_rd);
endmodule // phy_status_register
`default_nettype wire

// [tb/station_manager.sv]
`timescale 1ns/1ps
`default_nettype none
module station_manager(
   input wire logic sys_clk,
   output logic [4:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [15:0] reg_wdata
);
   initial begin
      reg_addr = 5'h01;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   // Released write data is inverted so a stale word never looks valid.
   task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_rd <= !wr;
      reg_wr <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
endmodule // station_manager
`default_nettype wire

// [tb/tb_phy_status_register.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_phy_status_register;
   import phy_status_pkg::*;
   logic sys_clk = 0, nrst = 0, ovr = 0, mrd = 0, an_en = 0, an_c = 0, rf = 0, lk = 1, jb = 0, rd, wr;
   logic [4:0] a;
   logic [15:0] wd, rdata;
   int err_total = 0, n_checks = 0;
   always #4 sys_clk = ~sys_clk;
   station_manager u_mgr(.sys_clk(sys_clk), .reg_addr(a), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd));
   phy_status_register u_dut(.sys_clk(sys_clk), .nrst(nrst), .reg_addr(a), .reg_rd(rd), .reg_wr(wr),
      .reg_wdata(wd), .override_writable(ovr), .mirror_rd(mrd), .an_enabled(an_en), .an_complete(an_c),
      .remote_fault(rf), .link_ok(lk), .jabber(jb), .reg_rdata(rdata));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_check(input logic [15:0] exp);
      u_mgr.acc(1'b0, STATUS_ADDR, 16'h0000);
      #1 check(rdata, exp);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_check(16'h7809);
      rd_check(16'h780D);
      u_mgr.acc(1'b1, STATUS_ADDR, 16'h0000);
      ovr <= 1'b1;
      u_mgr.acc(1'b1, 5'h02, 16'h0040);
      rd_check(16'h780D);
      u_mgr.acc(1'b1, STATUS_ADDR, 16'h0040);
      rd_check(16'h004D);
      @(posedge sys_clk);
      {an_en, an_c, rf, jb, lk} <= 5'b11110;
      @(posedge sys_clk);
      {an_en, an_c, rf, jb, lk} <= 5'b00001;
      rd_check(16'h007B);
      rd_check(16'h004D);
      @(posedge sys_clk);
      jb <= 1'b1;
      @(posedge sys_clk);
      {jb, mrd} <= 2'b01;
      @(posedge sys_clk);
      mrd <= 1'b0;
      rd_check(16'h004D);
      @(posedge sys_clk);
      {an_en, an_c, rf} <= 3'b011;
      @(posedge sys_clk);
      {rf, mrd} <= 2'b01;
      @(posedge sys_clk);
      {an_c, mrd} <= 2'b00;
      rd_check(16'h004D);
      u_mgr.acc(1'b1, STATUS_ADDR, 16'hF86F);
      rd_check(16'h784D);
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_check(16'h7809);
      end_of_test;
   end
   initial begin
      #5000;
      err_total++;
      end_of_test;
   end
endmodule // tb_phy_status_register
`default_nettype wire
